// File: verilog/gpi_capture_top.sv
// input edge capture port: pins, pending flags, config and wishbone slave
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps

module gpi_capture_top
  import gpi_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  // input pins
  input  wire logic             input_pin_zero_i,
  input  wire logic             input_pin_one_i,
  input  wire logic             input_pin_two_i,
  input  wire logic             input_pin_three_i,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [SEL_W-1:0] wb_sel_i,
  input  wire logic [DAT_W-1:0] wb_dat_i,
  output logic      [DAT_W-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  // interrupt
  output logic                  irq_o
);

  //----------------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------------
  typedef struct packed {
    bus_state_type         bus;
    logic                  ack;
    logic [DAT_W-1:0]      rdata;
    logic [NUM_PINS-1:0]   prev;
    logic [NUM_PINS-1:0]   pend;
    logic [NUM_PINS-1:0]   pol;
    logic [MODE_VEC_W-1:0] mode;
    logic [PORT_IDX_W-1:0] sel_port;
    logic [PIN_IDX_W-1:0]  sel_pin;
    logic [PIN_IDX_W-1:0]  kwd_pin;
    logic [NUM_PINS-1:0]   stat;
    logic [NUM_PINS-1:0]   en;
    logic                  irq;
  } top_state_type;

  localparam top_state_type STATE_RST = '{
    bus:      BUS_IDLE,
    ack:      1'b0,
    rdata:    '0,
    prev:     '0,
    pend:     PEND_RST,
    pol:      POL_RST,
    mode:     MODE_RST,
    sel_port: PORT_RST,
    sel_pin:  PIN_RST,
    kwd_pin:  PIN_RST,
    stat:     '0,
    en:       EN_RST,
    irq:      1'b0
  };

  top_state_type       state_ff;
  top_state_type       nxt_state;

  logic [NUM_PINS-1:0] raw_pins;
  logic [NUM_PINS-1:0] sync_pins;
  logic [NUM_PINS-1:0] hit_c;
  logic [NUM_PINS-1:0] lvl_c;
  logic [NUM_PINS-1:0] clr_pend;
  logic [NUM_PINS-1:0] clr_stat;
  logic [DAT_W-1:0]    rd_c;
  logic                req;
  logic                port_ok;
  logic                take;

  //----------------------------------------------------------------------------
  // pin front end
  //----------------------------------------------------------------------------
  // the four pins form the single input port
  assign raw_pins = {input_pin_three_i, input_pin_two_i,
                     input_pin_one_i, input_pin_zero_i};

  gpi_sync2 u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .din_i      (raw_pins),
    .dout_o     (sync_pins)
  );

  gpi_edge_detect u_edge (
    .cur_i  (sync_pins),
    .prev_i (state_ff.prev),
    .pol_i  (state_ff.pol),
    .mode_i (state_ff.mode),
    .hit_o  (hit_c)
  );

  // active-level view: a low-active pin reads one when the wire is low
  assign lvl_c   = ~(sync_pins ^ state_ff.pol);
  assign port_ok = (state_ff.sel_port == PORT_IDX);
  assign req     = wb_cyc_i && wb_stb_i;
  assign take    = req && (state_ff.bus == BUS_IDLE);

  //----------------------------------------------------------------------------
  // read multiplexer
  //----------------------------------------------------------------------------
  // unmapped and write-only offsets read as zero
  always_comb begin
    rd_c = '0;
    case (wb_adr_i)
      OFF_PORT_STATE: begin
        if (port_ok) begin
          rd_c[NUM_PINS-1:0] = lvl_c;
        end
      end
      OFF_PIN_STATE: begin
        if (port_ok) begin
          rd_c[0] = lvl_c[state_ff.sel_pin];
        end
      end
      OFF_PIN_PEND: begin
        if (port_ok) begin
          rd_c[0] = state_ff.pend[state_ff.sel_pin];
        end
      end
      OFF_PORT_PEND: begin
        if (port_ok) begin
          rd_c[NUM_PINS-1:0] = state_ff.pend;
        end
      end
      OFF_POLARITY:   rd_c[NUM_PINS-1:0]   = state_ff.pol;
      OFF_EDGE_MODE:  rd_c[MODE_VEC_W-1:0] = state_ff.mode;
      OFF_READ_SEL: begin
        rd_c[SEL_PIN_LSB +: PIN_IDX_W]   = state_ff.sel_pin;
        rd_c[SEL_PORT_LSB +: PORT_IDX_W] = state_ff.sel_port;
      end
      OFF_KWD_PIN:    rd_c[PIN_IDX_W-1:0] = state_ff.kwd_pin;
      OFF_IRQ_STATUS: rd_c[NUM_PINS-1:0]  = state_ff.stat;
      OFF_IRQ_ENABLE: rd_c[NUM_PINS-1:0]  = state_ff.en;
      default:        rd_c = '0;
    endcase
  end

  //----------------------------------------------------------------------------
  // read side effects and the interrupt status clear write
  //----------------------------------------------------------------------------
  // clearing reads act only on the edge that takes the request
  always_comb begin
    clr_pend = '0;
    clr_stat = '0;
    if (take && !wb_we_i && port_ok) begin
      if (wb_adr_i == OFF_PIN_PEND) begin
        clr_pend = pin_mask(state_ff.sel_pin);
      end
      if (wb_adr_i == OFF_PORT_PEND) begin
        clr_pend = '1;
      end
    end
    if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFF_IRQ_CLEAR) begin
      clr_stat = wb_dat_i[NUM_PINS-1:0];
    end
  end

  //----------------------------------------------------------------------------
  // next state
  //----------------------------------------------------------------------------
  always_comb begin
    nxt_state      = state_ff;
    nxt_state.prev = sync_pins;
    // an edge in the clearing cycle survives: set wins over clear
    nxt_state.pend = (state_ff.pend & ~clr_pend) | hit_c;
    nxt_state.stat = (state_ff.stat & ~clr_stat) | hit_c;

    // bus handshake: one answer per request, then one idle cycle
    case (state_ff.bus)
      BUS_IDLE: begin
        nxt_state.ack = 1'b0;
        if (req) begin
          nxt_state.bus   = BUS_ACK;
          nxt_state.ack   = 1'b1;
          nxt_state.rdata = wb_we_i ? '0 : rd_c;
        end
      end
      BUS_ACK: begin
        nxt_state.bus = BUS_IDLE;
        nxt_state.ack = 1'b0;
      end
      default: begin
        nxt_state.bus = BUS_IDLE;
        nxt_state.ack = 1'b0;
      end
    endcase

    // register writes, only the low byte lanes carry fields
    if (take && wb_we_i) begin
      case (wb_adr_i)
        OFF_POLARITY: begin
          if (wb_sel_i[0]) begin
            nxt_state.pol = wb_dat_i[NUM_PINS-1:0];
          end
        end
        OFF_EDGE_MODE: begin
          if (wb_sel_i[0]) begin
            nxt_state.mode = wb_dat_i[MODE_VEC_W-1:0];
          end
        end
        OFF_READ_SEL: begin
          if (wb_sel_i[0]) begin
            nxt_state.sel_pin = wb_dat_i[SEL_PIN_LSB +: PIN_IDX_W];
          end
          if (wb_sel_i[1]) begin
            nxt_state.sel_port = wb_dat_i[SEL_PORT_LSB +: PORT_IDX_W];
          end
        end
        OFF_KWD_PIN: begin
          if (wb_sel_i[0]) begin
            nxt_state.kwd_pin = wb_dat_i[PIN_IDX_W-1:0];
          end
        end
        OFF_IRQ_ENABLE: begin
          if (wb_sel_i[0]) begin
            nxt_state.en = wb_dat_i[NUM_PINS-1:0];
          end
        end
        default: begin
          nxt_state.en = state_ff.en;
        end
      endcase
    end

    // level interrupt from enabled sticky bits
    nxt_state.irq = |(nxt_state.stat & nxt_state.en);
  end

  // single register bank
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign wb_dat_o = state_ff.rdata;
  assign wb_ack_o = state_ff.ack;
  assign irq_o    = state_ff.irq;

  //----------------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // answer of a read at a given offset
  sequence s_read_ack(logic [ADR_W-1:0] off);
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == off;
  endsequence

  // selector write with both lanes
  sequence s_sel_write;
    wb_ack_o && $past(wb_we_i) && $past(wb_adr_i) == OFF_READ_SEL &&
      $past(wb_sel_i[0]) && $past(wb_sel_i[1]);
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_latency: assert property (take |=> wb_ack_o)
    else $error("request not answered on the next edge");

  a_pend_set: assert property ((|hit_c) |=>
    (state_ff.pend & $past(hit_c)) == $past(hit_c))
    else $error("detected edge did not set its pending flag");

  a_pend_hold: assert property ((!(|hit_c) && !take) |=>
    $stable(state_ff.pend))
    else $error("pending flags changed with no edge and no read");

  a_pin_clear: assert property (s_read_ack(OFF_PIN_PEND) and
    $past(port_ok) |-> !state_ff.pend[$past(state_ff.sel_pin)] ||
    $past(hit_c[state_ff.sel_pin]))
    else $error("pin pending read did not clear its flag");

  a_port_clear: assert property (s_read_ack(OFF_PORT_PEND) and
    $past(port_ok) |-> state_ff.pend == $past(hit_c) &&
    wb_dat_o[NUM_PINS-1:0] == $past(state_ff.pend))
    else $error("port pending read wrong or did not clear");

  a_port_state: assert property (s_read_ack(OFF_PORT_STATE) |->
    wb_dat_o[NUM_PINS-1:0] == ($past(port_ok) ? $past(lvl_c) : '0))
    else $error("port state read does not match pin levels");

  a_pin_state: assert property (s_read_ack(OFF_PIN_STATE) and
    $past(port_ok) |-> wb_dat_o[0] == $past(lvl_c[state_ff.sel_pin]))
    else $error("pin state read does not match selected pin");

  a_sel_store: assert property (s_sel_write |->
    state_ff.sel_pin == $past(wb_dat_i[SEL_PIN_LSB +: PIN_IDX_W]) &&
    state_ff.sel_port == $past(wb_dat_i[SEL_PORT_LSB +: PORT_IDX_W]))
    else $error("selector write not stored");

  a_sel_readback: assert property (s_read_ack(OFF_READ_SEL) |->
    wb_dat_o[SEL_PIN_LSB +: PIN_IDX_W] == state_ff.sel_pin &&
    wb_dat_o[SEL_PORT_LSB +: PORT_IDX_W] == state_ff.sel_port)
    else $error("selector readback differs from stored indices");

  a_mode_quiet: assert property (
    pin_mode(state_ff.mode, PIN_RST) == MODE_NONE |=> !$rose(state_ff.pend[0]))
    else $error("pending flag rose on a pin with capture disabled");

  a_kwd_readback: assert property (s_read_ack(OFF_KWD_PIN) |->
    wb_dat_o[PIN_IDX_W-1:0] == state_ff.kwd_pin)
    else $error("keyword pin index readback wrong");

  a_irq_level: assert property (
    !(|(state_ff.stat & state_ff.en)) |-> !irq_o)
    else $error("interrupt high with no enabled status bit");

endmodule : gpi_capture_top

// File: verilog/gpi_pkg.sv
// register map, field layout and shared types of the input edge capture port
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package gpi_pkg;

  //----------------------------------------------------------------------------
  // sizes
  //----------------------------------------------------------------------------
  localparam int NUM_PINS   = 4;
  localparam int PIN_IDX_W  = 2;
  localparam int PORT_IDX_W = 4;
  localparam int MODE_W     = 2;
  localparam int MODE_VEC_W = NUM_PINS * MODE_W;
  localparam int ADR_W      = 6;
  localparam int DAT_W      = 32;
  localparam int SEL_W      = 4;

  //----------------------------------------------------------------------------
  // register byte offsets
  //----------------------------------------------------------------------------
  localparam logic [ADR_W-1:0] OFF_PORT_STATE = 6'h00;
  localparam logic [ADR_W-1:0] OFF_PIN_STATE  = 6'h04;
  localparam logic [ADR_W-1:0] OFF_PIN_PEND   = 6'h08;
  localparam logic [ADR_W-1:0] OFF_PORT_PEND  = 6'h0c;
  localparam logic [ADR_W-1:0] OFF_POLARITY   = 6'h10;
  localparam logic [ADR_W-1:0] OFF_EDGE_MODE  = 6'h14;
  localparam logic [ADR_W-1:0] OFF_READ_SEL   = 6'h18;
  localparam logic [ADR_W-1:0] OFF_KWD_PIN    = 6'h1c;
  localparam logic [ADR_W-1:0] OFF_IRQ_STATUS = 6'h20;
  localparam logic [ADR_W-1:0] OFF_IRQ_CLEAR  = 6'h24;
  localparam logic [ADR_W-1:0] OFF_IRQ_ENABLE = 6'h28;

  //----------------------------------------------------------------------------
  // fields, port index and reset values
  //----------------------------------------------------------------------------
  localparam int SEL_PIN_LSB  = 0;
  localparam int SEL_PORT_LSB = 8;
  localparam logic [PORT_IDX_W-1:0] PORT_IDX = 4'h0;
  localparam logic [NUM_PINS-1:0]   POL_RST  = 4'hf;
  localparam logic [MODE_VEC_W-1:0] MODE_RST = 8'h00;
  localparam logic [NUM_PINS-1:0]   PEND_RST = 4'h0;
  localparam logic [NUM_PINS-1:0]   EN_RST   = 4'h0;
  localparam logic [PIN_IDX_W-1:0]  PIN_RST  = 2'h0;
  localparam logic [PORT_IDX_W-1:0] PORT_RST = 4'h0;

  //----------------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------------
  typedef enum logic [MODE_W-1:0] {
    MODE_NONE = 2'b00,
    MODE_FALL = 2'b01,
    MODE_RISE = 2'b10,
    MODE_BOTH = 2'b11
  } edge_mode_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_type;

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  // two mode bits of one pin out of the packed mode vector
  function automatic logic [MODE_W-1:0] pin_mode(input logic [MODE_VEC_W-1:0] modes,
                                                 input logic [PIN_IDX_W-1:0]  idx);
    return modes[{idx, 1'b0} +: MODE_W];
  endfunction : pin_mode

  // one-hot mask of a pin index
  function automatic logic [NUM_PINS-1:0] pin_mask(input logic [PIN_IDX_W-1:0] idx);
    logic [NUM_PINS-1:0] m;
    m      = '0;
    m[idx] = 1'b1;
    return m;
  endfunction : pin_mask

endpackage : gpi_pkg

// File: verilog/gpi_sync2.sv
// two-stage synchroniser for the input pins
`timescale 1ns/100ps

module gpi_sync2
  import gpi_pkg::*;
(
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                rstn_i,
  // raw and synchronised levels
  input  wire logic [NUM_PINS-1:0] din_i,
  output logic      [NUM_PINS-1:0] dout_o
);

  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
  } sync_state_type;

  sync_state_type state_ff;
  sync_state_type nxt_state;

  // first stage feeds only the second one
  always_comb begin
    nxt_state    = state_ff;
    nxt_state.s1 = din_i;
    nxt_state.s2 = state_ff.s1;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign dout_o = state_ff.s2;

  // a level held steady reaches the output after two edges
  a_sync_delay: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ($past(rstn_i) && $past(rstn_i, 2) && $stable(din_i) && $past($stable(din_i)))
      |-> dout_o == $past(din_i, 2))
    else $error("synchroniser output does not follow input after two cycles");

endmodule : gpi_sync2

// File: verilog/gpi_edge_detect.sv
// per-pin edge qualifier: polarity and edge mode decide which edges count
`timescale 1ns/100ps

module gpi_edge_detect
  import gpi_pkg::*;
(
  // synchronised levels now and one cycle earlier
  input  wire logic [NUM_PINS-1:0]   cur_i,
  input  wire logic [NUM_PINS-1:0]   prev_i,
  // per-pin configuration
  input  wire logic [NUM_PINS-1:0]   pol_i,
  input  wire logic [MODE_VEC_W-1:0] mode_i,
  // qualifying edge seen, one bit per pin
  output logic      [NUM_PINS-1:0]   hit_o
);

  // edges are judged on the active-level view, so low polarity swaps them
  always_comb begin
    logic              rise;
    logic              fall;
    logic [MODE_W-1:0] m;
    rise  = 1'b0;
    fall  = 1'b0;
    m     = '0;
    hit_o = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      rise = pol_i[i] ? (cur_i[i] & ~prev_i[i]) : (~cur_i[i] & prev_i[i]);
      fall = pol_i[i] ? (~cur_i[i] & prev_i[i]) : (cur_i[i] & ~prev_i[i]);
      m    = pin_mode(mode_i, PIN_IDX_W'(i));
      case (m)
        MODE_FALL: hit_o[i] = fall;
        MODE_RISE: hit_o[i] = rise;
        MODE_BOTH: hit_o[i] = rise | fall;
        default:   hit_o[i] = 1'b0;
      endcase
    end
  end

endmodule : gpi_edge_detect

// File: tb/pin_source.sv
// partner model: external logic levels driving the four input pins
`timescale 1ns/100ps

module pin_source (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // wanted levels and how many cycles to lag before showing them
  input  wire logic [3:0] want_i,
  input  wire logic [1:0] lag_i,
  // driven pin levels, always driven, never released
  output logic      [3:0] pins_o
);
  logic [1:0] cnt_ff;

  // a slow source shows a new level only after its lag has run out
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_ff <= 2'h0;
      pins_o <= 4'h0;
    end else if (want_i === pins_o) begin
      cnt_ff <= lag_i;
    end else if (cnt_ff != 2'h0) begin
      cnt_ff <= cnt_ff - 2'h1;
    end else begin
      pins_o <= want_i;
    end
  end
endmodule : pin_source

// File: tb/testbench.sv
// self-checking bench of the input edge capture port against an integer model
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module testbench;
  import gpi_pkg::*;
  //----------------------------------------------------------------------------
  // signals
  //----------------------------------------------------------------------------
  logic             core_clk_i = 1'b0;
  logic             rstn_i     = 1'b0;
  logic             cyc        = 1'b0;
  logic             we         = 1'b0;
  logic [ADR_W-1:0] adr        = '0;
  logic [DAT_W-1:0] wdat       = '0;
  logic [DAT_W-1:0] rdat;
  logic             ack;
  logic             irq;
  logic [3:0]       want       = 4'h0;
  logic [1:0]       lag        = 2'h0;
  logic [3:0]       pins;
  int               fails      = 0;
  int               n_tests    = 0;
  // model state
  int               m_pin, m_pol, m_mode, m_pend, m_stat, m_en;
  int               rst_adr[$] = '{OFF_POLARITY, OFF_EDGE_MODE, OFF_READ_SEL, OFF_KWD_PIN,
                                   OFF_IRQ_STATUS, OFF_IRQ_ENABLE, OFF_PORT_PEND, 6'h2c};
  int               rst_exp[$] = '{15, 0, 0, 0, 0, 0, 0, 0};

  //----------------------------------------------------------------------------
  // clock, design and partner
  //----------------------------------------------------------------------------
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end

  gpi_capture_top gpi_capture_top_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .input_pin_zero_i(pins[0]), .input_pin_one_i(pins[1]),
    .input_pin_two_i(pins[2]), .input_pin_three_i(pins[3]),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq)
  );

  pin_source pin_source_i (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .want_i(want), .lag_i(lag), .pins_o(pins)
  );

  //----------------------------------------------------------------------------
  // tasks
  //----------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : idle

  // one classic cycle; held until ack is seen, a lost ack counts as a mismatch
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input int d,
                    output logic [DAT_W-1:0] q);
    int n;
    n = 0;
    @(posedge core_clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= DAT_W'(d);
    do begin
      @(posedge core_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    if (n >= 64) fails++;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [ADR_W-1:0] a, input int d);
    logic [DAT_W-1:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [ADR_W-1:0] a, output logic [DAT_W-1:0] q);
    wb(1'b0, a, 0, q);
  endtask : rd

  // pin reads 1 at its active level
  function automatic int view(input int raw, input int pol);
    return ~(raw ^ pol) & 15;
  endfunction : view

  // new pin levels; polarity changes alone never count as edges in the model
  task automatic set_pins(input int v);
    int o, nv, md;
    o  = view(m_pin, m_pol);
    nv = view(v, m_pol);
    want <= 4'(v);
    lag  <= 2'($urandom % 4);
    idle(12);
    for (int p = 0; p < 4; p++) begin
      md = (m_mode >> (2 * p)) & 3;
      if (((md & 2) != 0 && !o[p] && nv[p]) || ((md & 1) != 0 && o[p] && !nv[p])) begin
        m_pend |= 1 << p;
        m_stat |= 1 << p;
      end
    end
    m_pin = v;
  endtask : set_pins

  //----------------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------------
  initial begin
    logic [DAT_W-1:0] q;
    int pol, md, v, p;
    void'($urandom(32'h578fbb5d));
    {m_pin, m_pol, m_mode, m_pend, m_stat, m_en} = {0, 15, 0, 0, 0, 0};
    idle(20);
    `CHK("irq in reset", 1'b0, irq)
    rstn_i <= 1'b1;
    idle(1);
    foreach (rst_adr[k]) begin
      rd(6'(rst_adr[k]), q);
      `CHK("reset value", rst_exp[k], q)
    end
    $display("test reset values done");
    for (int i = 0; i < 48; i++) begin
      pol = $urandom % 16;
      md  = 0;
      for (int k = 0; k < 4; k++) md |= ((i + k) % 4) << (2 * k);
      m_en = $urandom % 16;
      wr(OFF_POLARITY, pol);
      wr(OFF_EDGE_MODE, md);
      wr(OFF_IRQ_ENABLE, m_en);
      m_pol  = pol;
      m_mode = md;
      rd(OFF_EDGE_MODE, q);
      `CHK("edge mode", md, q)
      set_pins($urandom % 16);
      `CHK("irq level", logic'((m_stat & m_en) != 0), irq)
      rd(OFF_PORT_STATE, q);
      `CHK("port state", view(m_pin, m_pol), q)
      p = $urandom % 4;
      wr(OFF_READ_SEL, p);
      rd(OFF_PIN_STATE, q);
      `CHK("pin state", (view(m_pin, m_pol) >> p) & 1, q)
      rd(OFF_PIN_PEND, q);
      `CHK("pin pending", (m_pend >> p) & 1, q)
      m_pend &= ~(1 << p);
      v = 1 + $urandom % 15;
      wr(OFF_READ_SEL, (v << 8) | p);
      rd(OFF_READ_SEL, q);
      `CHK("selector", (v << 8) | p, q)
      rd(OFF_PORT_PEND, q);
      `CHK("other port pending", 0, q)
      wr(OFF_READ_SEL, p);
      rd(OFF_PORT_PEND, q);
      `CHK("port pending", m_pend, q)
      m_pend = 0;
      rd(OFF_PORT_PEND, q);
      `CHK("pending cleared", 0, q)
      wr(OFF_KWD_PIN, v);
      rd(OFF_KWD_PIN, q);
      `CHK("keyword pin", v & 3, q)
      wr(OFF_IRQ_STATUS, 15);
      rd(OFF_IRQ_STATUS, q);
      `CHK("irq status", m_stat, q)
      v = $urandom % 16;
      wr(OFF_IRQ_CLEAR, v);
      m_stat &= ~v;
      idle(2);
      `CHK("irq after clear", logic'((m_stat & m_en) != 0), irq)
    end
    $display("test random pin traffic done");
    report_and_stop();
  end

  // watchdog: the run needs a few thousand cycles
  initial begin
    #(40 * 20000);
    fails++;
    report_and_stop();
  end
endmodule : testbench
